/* File: core/adc_gain_track_window_ctrl.v */
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"
// Summary of operation
// - thirteen gain bits across three registers
// - gain word is upper byte, lower[7:4]
// - extra bit adds one sixty-fourth gain
// - extra gain bit resets to one
// - gain equals word/4096 plus extra/64
// - bits 3:2 select tracking mode
// - bits 1:0 select post-track time
// - burst off follows enable; on+enable stays powered
// - burst, enable clear: power up (n+1)*200ns
// - tracking register 0xBA page 0, resets 0xFF
// - window compares result against both limits
// - limit ordering selects inside or outside
// - window flag readable, also interrupt request
// - compare only after full repeat count
module adc_gain_track_window_ctrl (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_page,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    input  wire [7:0]  sfr_wdata,
    output reg  [7:0]  sfr_rdata_r,
    input  wire        convert_start,
    input  wire        result_valid,
    input  wire        accum_complete,
    input  wire [15:0] result_data,
    output reg  [11:0] gain_word_r,
    output reg         extra_gain_bit_r,
    output reg  [12:0] gain_total_r,
    output reg  [1:0]  tracking_mode_sel_r,
    output reg         tracking_mode_reserved_r,
    output reg  [4:0]  post_track_sar_clocks_r,
    output reg  [4:0]  post_track_sys_cycles_r,
    output reg         converter_power_r,
    output reg         powerup_ready_r,
    output reg         window_irq_r
);
    reg        rst_meta_r;
    reg        rst_sync_r;
    reg [7:0]  tracking_control_reg_r;
    reg [7:0]  gain_word_upper_r;
    reg [7:0]  gain_word_lower_r;
    reg [7:0]  gain_extra_reg_r;
    reg        converter_enable_r;
    reg        burst_mode_on_r;
    reg        window_flag_r;
    reg [7:0]  upper_limit_high_r;
    reg [7:0]  upper_limit_low_r;
    reg [7:0]  lower_limit_high_r;
    reg [7:0]  lower_limit_low_r;
    reg        start_meta_r;
    reg        start_sync_r;
    reg        start_prev_r;
    reg        valid_meta_r;
    reg        valid_sync_r;
    reg        valid_prev_r;
    reg        accum_meta_r;
    reg        accum_sync_r;
    reg [15:0] result_meta_r;
    reg [15:0] result_sync_r;
    reg [7:0]  rdata_nxt;
    reg [4:0]  sar_clocks_nxt;
    wire       page_ok;
    wire       wr_track;
    wire       wr_ctrl;
    wire       wr_gain_upper;
    wire       wr_gain_lower;
    wire       wr_gain_extra;
    wire       wr_upper_high;
    wire       wr_upper_low;
    wire       wr_lower_high;
    wire       wr_lower_low;
    wire       flag_set;
    wire       flag_clear;
    wire [15:0] upper_limit;
    wire [15:0] lower_limit;
    wire       above_upper;
    wire       below_lower;
    wire       window_hit;
    wire       result_event;
    wire       start_event;
    wire       pu_busy;
    wire       pu_done;

    // reset release through two flops
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // conversion core inputs synchronised
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            start_meta_r  <= 1'b0;
            start_sync_r  <= 1'b0;
            start_prev_r  <= 1'b0;
            valid_meta_r  <= 1'b0;
            valid_sync_r  <= 1'b0;
            valid_prev_r  <= 1'b0;
            accum_meta_r  <= 1'b0;
            accum_sync_r  <= 1'b0;
            result_meta_r <= 16'h0000;
            result_sync_r <= 16'h0000;
        end else begin
            start_meta_r  <= convert_start;
            start_sync_r  <= start_meta_r;
            start_prev_r  <= start_sync_r;
            valid_meta_r  <= result_valid;
            valid_sync_r  <= valid_meta_r;
            valid_prev_r  <= valid_sync_r;
            accum_meta_r  <= accum_complete;
            accum_sync_r  <= accum_meta_r;
            result_meta_r <= result_data;
            result_sync_r <= result_meta_r;
        end
    end

    assign start_event  = start_sync_r && !start_prev_r;
    assign result_event = valid_sync_r && !valid_prev_r;

    assign page_ok  = (sfr_page == `PAGE_TRACKING_CONTROL);
    assign wr_track = sfr_wr && page_ok && (sfr_addr == `ADDR_TRACKING_CONTROL);
    assign wr_ctrl  = sfr_wr && page_ok && (sfr_addr == `ADDR_CONVERTER_CTRL);
    assign wr_gain_upper = sfr_wr && page_ok && (sfr_addr == `ADDR_GAIN_UPPER);
    assign wr_gain_lower = sfr_wr && page_ok && (sfr_addr == `ADDR_GAIN_LOWER);
    assign wr_gain_extra = sfr_wr && page_ok && (sfr_addr == `ADDR_GAIN_EXTRA);
    assign wr_upper_high = sfr_wr && page_ok && (sfr_addr == `ADDR_UPPER_LIMIT_HIGH);
    assign wr_upper_low  = sfr_wr && page_ok && (sfr_addr == `ADDR_UPPER_LIMIT_LOW);
    assign wr_lower_high = sfr_wr && page_ok && (sfr_addr == `ADDR_LOWER_LIMIT_HIGH);
    assign wr_lower_low  = sfr_wr && page_ok && (sfr_addr == `ADDR_LOWER_LIMIT_LOW);
    assign flag_set      = result_event && accum_sync_r && window_hit;
    assign flag_clear    = wr_ctrl && !sfr_wdata[`CTRL_WINDOW_BIT];

    assign upper_limit = {upper_limit_high_r, upper_limit_low_r};
    assign lower_limit = {lower_limit_high_r, lower_limit_low_r};
    assign above_upper = (result_sync_r > upper_limit);
    assign below_lower = (result_sync_r < lower_limit);
    // lower above upper: inside window; otherwise outside
    assign window_hit  = (lower_limit > upper_limit) ? (above_upper && below_lower)
                                                     : (above_upper || below_lower);
    // tracking and gain registers
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            tracking_control_reg_r <= `RST_TRACKING_CONTROL;
            gain_word_upper_r      <= `RST_GAIN_UPPER;
            gain_word_lower_r      <= `RST_GAIN_LOWER;
            gain_extra_reg_r       <= `RST_GAIN_EXTRA;
        end else begin
            if (wr_track)
                tracking_control_reg_r <= sfr_wdata;
            if (wr_gain_upper)
                gain_word_upper_r <= sfr_wdata;
            if (wr_gain_lower)
                gain_word_lower_r <= sfr_wdata & 8'hF0;
            if (wr_gain_extra)
                gain_extra_reg_r <= sfr_wdata & 8'h01;
        end
    end

    // window limit registers
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            upper_limit_high_r <= `RST_UPPER_LIMIT_HIGH;
            upper_limit_low_r  <= `RST_UPPER_LIMIT_LOW;
            lower_limit_high_r <= `RST_LOWER_LIMIT_HIGH;
            lower_limit_low_r  <= `RST_LOWER_LIMIT_LOW;
        end else begin
            if (wr_upper_high)
                upper_limit_high_r <= sfr_wdata;
            if (wr_upper_low)
                upper_limit_low_r <= sfr_wdata;
            if (wr_lower_high)
                lower_limit_high_r <= sfr_wdata;
            if (wr_lower_low)
                lower_limit_low_r <= sfr_wdata;
        end
    end

    // converter control bits
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            converter_enable_r <= 1'b0;
            burst_mode_on_r    <= 1'b0;
        end else if (wr_ctrl) begin
            converter_enable_r <= sfr_wdata[`CTRL_ENABLE_BIT];
            burst_mode_on_r    <= sfr_wdata[`CTRL_BURST_BIT];
        end
    end

    // window flag, set wins over software clear
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r)
            window_flag_r <= 1'b0;
        else if (flag_set)
            window_flag_r <= 1'b1;
        else if (flag_clear)
            window_flag_r <= 1'b0;
    end

    // read mux
    always @* begin
        rdata_nxt = 8'h00;
        if (page_ok) begin
            case (sfr_addr)
                `ADDR_TRACKING_CONTROL: rdata_nxt = tracking_control_reg_r;
                `ADDR_GAIN_UPPER:       rdata_nxt = gain_word_upper_r;
                `ADDR_GAIN_LOWER:       rdata_nxt = gain_word_lower_r;
                `ADDR_GAIN_EXTRA:       rdata_nxt = gain_extra_reg_r;
                `ADDR_CONVERTER_CTRL:   rdata_nxt = {converter_enable_r, burst_mode_on_r, 2'h0,
                                                     window_flag_r, 3'h0};
                `ADDR_UPPER_LIMIT_HIGH: rdata_nxt = upper_limit_high_r;
                `ADDR_UPPER_LIMIT_LOW:  rdata_nxt = upper_limit_low_r;
                `ADDR_LOWER_LIMIT_HIGH: rdata_nxt = lower_limit_high_r;
                `ADDR_LOWER_LIMIT_LOW:  rdata_nxt = lower_limit_low_r;
                default:                rdata_nxt = 8'h00;
            endcase
        end
    end

    // post-track clock count decode
    always @* begin
        case (tracking_control_reg_r[`TK_MSB:`TK_LSB])
            2'h0:    sar_clocks_nxt = `TK_CLOCKS_0;
            2'h1:    sar_clocks_nxt = `TK_CLOCKS_1;
            2'h2:    sar_clocks_nxt = `TK_CLOCKS_2;
            2'h3:    sar_clocks_nxt = `TK_CLOCKS_3;
            default: sar_clocks_nxt = `TK_CLOCKS_0;
        endcase
    end

    powerup_timer u_powerup_timer (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_r),
        .start      (start_event && burst_mode_on_r && !converter_enable_r),
        .step_count (tracking_control_reg_r[`PWR_MSB:`PWR_LSB]),
        .busy_r     (pu_busy),
        .done_r     (pu_done)
    );

    // read data register
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r)
            sfr_rdata_r <= 8'h00;
        else if (sfr_rd)
            sfr_rdata_r <= rdata_nxt;
    end

    // gain outputs
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            gain_word_r      <= 12'h000;
            extra_gain_bit_r <= 1'b1;
            gain_total_r     <= 13'h0000;
        end else begin
            gain_word_r      <= {gain_word_upper_r, gain_word_lower_r[`GAIN_LOW_MSB:`GAIN_LOW_LSB]};
            extra_gain_bit_r <= gain_extra_reg_r[`EXTRA_GAIN_BIT];
            // gain in units of 1/4096: 1/64 is 64 units
            gain_total_r     <= {1'b0, gain_word_upper_r, gain_word_lower_r[`GAIN_LOW_MSB:`GAIN_LOW_LSB]}
                                + {6'h00, gain_extra_reg_r[`EXTRA_GAIN_BIT], 6'h00};
        end
    end

    // tracking outputs
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            tracking_mode_sel_r      <= `TM_DUAL;
            tracking_mode_reserved_r <= 1'b0;
            post_track_sar_clocks_r  <= `TK_CLOCKS_3;
            post_track_sys_cycles_r  <= `TK_SYS_CYCLES;
        end else begin
            tracking_mode_sel_r      <= tracking_control_reg_r[`TM_MSB:`TM_LSB];
            tracking_mode_reserved_r <= (tracking_control_reg_r[`TM_MSB:`TM_LSB] == `TM_RESERVED);
            post_track_sar_clocks_r  <= sar_clocks_nxt;
            post_track_sys_cycles_r  <= `TK_SYS_CYCLES;
        end
    end

    // power and window outputs
    always @(posedge clk_sys or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            converter_power_r <= 1'b0;
            powerup_ready_r   <= 1'b0;
            window_irq_r      <= 1'b0;
        end else begin
            if (!burst_mode_on_r)
                converter_power_r <= converter_enable_r;
            else if (converter_enable_r)
                converter_power_r <= 1'b1;
            else
                converter_power_r <= pu_busy || (start_event && !pu_busy);
            powerup_ready_r <= pu_done;
            window_irq_r    <= window_flag_r;
        end
    end
endmodule // adc_gain_track_window_ctrl

/* File: core/adc_ctrl_defs.vh */
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH
// special function register addresses
`define ADDR_TRACKING_CONTROL 8'hBA
`define PAGE_TRACKING_CONTROL 8'h00
`define ADDR_GAIN_UPPER       8'hC0
`define ADDR_GAIN_LOWER       8'hC1
`define ADDR_GAIN_EXTRA       8'hC2
`define ADDR_CONVERTER_CTRL   8'hC3
`define ADDR_UPPER_LIMIT_HIGH 8'hC4
`define ADDR_UPPER_LIMIT_LOW  8'hC5
`define ADDR_LOWER_LIMIT_HIGH 8'hC6
`define ADDR_LOWER_LIMIT_LOW  8'hC7
// reset values
`define RST_TRACKING_CONTROL  8'hFF
`define RST_GAIN_UPPER        8'h00
`define RST_GAIN_LOWER        8'h00
`define RST_GAIN_EXTRA        8'h01
`define RST_UPPER_LIMIT_HIGH  8'hFF
`define RST_UPPER_LIMIT_LOW   8'hFF
`define RST_LOWER_LIMIT_HIGH  8'h00
`define RST_LOWER_LIMIT_LOW   8'h00
// field positions
`define PWR_MSB               7
`define PWR_LSB               4
`define TM_MSB                3
`define TM_LSB                2
`define TK_MSB                1
`define TK_LSB                0
`define GAIN_LOW_MSB          7
`define GAIN_LOW_LSB          4
`define EXTRA_GAIN_BIT        0
`define CTRL_ENABLE_BIT       7
`define CTRL_BURST_BIT        6
`define CTRL_WINDOW_BIT       3
// tracking mode codes
`define TM_RESERVED           2'h0
`define TM_POST               2'h1
`define TM_PRE                2'h2
`define TM_DUAL               2'h3
// post-track conversion clock counts and system cycle count
`define TK_CLOCKS_0           5'h02
`define TK_CLOCKS_1           5'h04
`define TK_CLOCKS_2           5'h10
`define TK_CLOCKS_3           5'h10
`define TK_SYS_CYCLES         5'h02
// power-up timing
`define POWERUP_STEP_NS       200
`define CLK_PERIOD_NS         4
`define POWERUP_STEP_CYCLES   ((`POWERUP_STEP_NS) / (`CLK_PERIOD_NS))
`endif

/* File: core/powerup_timer.v */
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"
// burst power-up wait: (count + 1) steps of 200 ns
module powerup_timer (
    input  wire       clk_sys,
    input  wire       rst_sync_n,
    input  wire       start,
    input  wire [3:0] step_count,
    output reg        busy_r,
    output reg        done_r
);
    localparam integer STEP_CYCLES = `POWERUP_STEP_CYCLES;
    localparam [5:0]   STEP_LAST   = STEP_CYCLES[5:0] - 6'h01;
    reg [5:0] tick_r;
    reg [3:0] step_r;
    always @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            tick_r <= 6'h00;
            step_r <= 4'h0;
        end else begin
            done_r <= 1'b0;
            if (start && !busy_r) begin
                busy_r <= 1'b1;
                // start cycle counts as first tick
                tick_r <= 6'h01;
                step_r <= step_count;
            end else if (busy_r) begin
                if (tick_r == STEP_LAST) begin
                    tick_r <= 6'h00;
                    if (step_r == 4'h0) begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                    end else begin
                        step_r <= step_r - 4'h1;
                    end
                end else begin
                    tick_r <= tick_r + 6'h01;
                end
            end
        end
    end
endmodule // powerup_timer

/* File: test/adc_gain_track_window_ctrl_props.sv */
`timescale 1ns/1ns
module adc_ctrl_props (
    input wire        clk_sys,
    input wire        rst_n,
    input wire [7:0]  sfr_addr,
    input wire [7:0]  sfr_page,
    input wire        sfr_wr,
    input wire        sfr_rd,
    input wire [7:0]  sfr_wdata,
    input wire [7:0]  sfr_rdata_r,
    input wire        accum_complete,
    input wire [11:0] gain_word_r,
    input wire        extra_gain_bit_r,
    input wire [12:0] gain_total_r,
    input wire [1:0]  tracking_mode_sel_r,
    input wire        tracking_mode_reserved_r,
    input wire [4:0]  post_track_sar_clocks_r,
    input wire [4:0]  post_track_sys_cycles_r,
    input wire        converter_power_r,
    input wire        window_irq_r
);
    reg  [2:0]  run_cnt_r;
    reg  [15:0] wd_pipe_r;
    reg  [7:0]  acc_hist_r;
    wire        settled = (run_cnt_r == 3'h7);
    wire [7:0]  wd_d2   = wd_pipe_r[15:8];
    wire [4:0]  sar_exp = (wd_d2[1:0] == 2'h0) ? 5'h02 : (wd_d2[1:0] == 2'h1) ? 5'h04 : 5'h10;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt_r  <= 3'h0;
            wd_pipe_r  <= 16'h0000;
            acc_hist_r <= 8'h00;
        end else begin
            run_cnt_r  <= settled ? run_cnt_r : run_cnt_r + 3'h1;
            wd_pipe_r  <= {wd_pipe_r[7:0], sfr_wdata};
            acc_hist_r <= {acc_hist_r[6:0], accum_complete};
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence wr_to(logic [7:0] a);
        settled && sfr_wr && sfr_page == 8'h00 && sfr_addr == a;
    endsequence
    upper_gain_a: assert property (wr_to(8'hC0) |-> ##2 gain_word_r[11:4] == wd_d2)
        else $error("gain word upper part wrong");
    extra_bit_a: assert property (wr_to(8'hC2) |-> ##2 extra_gain_bit_r == wd_d2[0])
        else $error("extra gain bit wrong");
    gain_sum_a: assert property (settled |-> gain_total_r == {1'b0, gain_word_r} + {6'h00, extra_gain_bit_r, 6'h00})
        else $error("gain total wrong");
    track_mode_a: assert property (wr_to(8'hBA) |-> ##2 tracking_mode_sel_r == wd_d2[3:2]
        && tracking_mode_reserved_r == (wd_d2[3:2] == 2'h0)) else $error("tracking mode wrong");
    post_track_a: assert property (wr_to(8'hBA) |-> ##2 post_track_sar_clocks_r == sar_exp
        && post_track_sys_cycles_r == 5'h02) else $error("post-track time wrong");
    read_zero_a: assert property (settled && sfr_rd && (sfr_page != 8'h00 || sfr_addr == 8'h00)
        |-> ##2 sfr_rdata_r == 8'h00) else $error("unmapped read not zero");
    irq_cause_a: assert property (settled && $rose(window_irq_r) |-> acc_hist_r != 8'h00)
        else $error("window flag without full accumulation");
    power_hold_a: assert property (wr_to(8'hC3) ##0 sfr_wdata[7] |-> ##2 converter_power_r [*8])
        else $error("converter not powered while enabled");
endmodule // adc_ctrl_props
bind adc_gain_track_window_ctrl adc_ctrl_props u_props (.*);

/* File: test/conv_core_model.sv */
`timescale 1ns/1ns
module conv_core_model (
    input  wire        clk_sys,
    output reg         convert_start,
    output reg         result_valid,
    output reg         accum_complete,
    output reg  [15:0] result_data
);
    initial begin
        convert_start  = 1'b0;
        result_valid   = 1'b0;
        accum_complete = 1'b0;
        result_data    = 16'hA5A5;
    end
    // start pulse, conversion delay, held result, then released data
    task convert(input [15:0] value, input acc, input integer delay);
        begin
            @(posedge clk_sys) #1 convert_start = 1'b1;
            repeat (4) @(posedge clk_sys);
            #1 convert_start = 1'b0;
            repeat (delay) @(posedge clk_sys);
            #1 result_data = value;
            accum_complete = acc;
            repeat (3) @(posedge clk_sys);
            #1 result_valid = 1'b1;
            repeat (6) @(posedge clk_sys);
            #1 result_valid = 1'b0;
            repeat (4) @(posedge clk_sys);
            #1 result_data = ~value;
            accum_complete = 1'b0;
        end
    endtask
endmodule // conv_core_model

/* File: test/adc_gain_track_window_ctrl_tb.sv */
`timescale 1ns/1ns
`define check(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module adc_gain_track_window_ctrl_tb;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  sfr_addr = 8'h00;
    reg  [7:0]  sfr_page = 8'h00;
    reg         sfr_wr = 1'b0;
    reg         sfr_rd = 1'b0;
    reg  [7:0]  sfr_wdata = 8'h00;
    reg  [7:0]  rd_val;
    reg  [4:0]  sar;
    integer     mismatches = 0;
    integer     tests_run = 0;
    integer     cyc = 0;
    integer     i;
    integer     hi;
    integer     pk;
    wire [7:0]  sfr_rdata_r;
    wire        convert_start, result_valid, accum_complete;
    wire [15:0] result_data;
    wire [11:0] gain_word_r;
    wire [12:0] gain_total_r;
    wire [1:0]  tracking_mode_sel_r;
    wire [4:0]  post_track_sar_clocks_r, post_track_sys_cycles_r;
    wire        extra_gain_bit_r, tracking_mode_reserved_r, converter_power_r, powerup_ready_r, window_irq_r;
    adc_gain_track_window_ctrl i_dut (.*);
    conv_core_model u_core (.*);
    always #2 clk_sys = ~clk_sys;
    task wr(input [7:0] a, input [7:0] d, input [7:0] p);
        begin
            @(posedge clk_sys) #1 sfr_addr = a;
            sfr_page = p;
            sfr_wdata = d;
            sfr_wr = 1'b1;
            @(posedge clk_sys) #1 sfr_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] p);
        begin
            @(posedge clk_sys) #1 sfr_addr = a;
            sfr_page = p;
            sfr_rd = 1'b1;
            @(posedge clk_sys) #1 sfr_rd = 1'b0;
            @(posedge clk_sys) #1 rd_val = sfr_rdata_r;
        end
    endtask
    task gcase(input [7:0] u, input [7:0] l, input x);
        begin
            wr(8'hC0, u, 8'h00);
            wr(8'hC1, l, 8'h00);
            wr(8'hC2, {7'h00, x}, 8'h00);
            repeat (2) @(posedge clk_sys);
            `check("gain word", {u, l[7:4]}, gain_word_r)
            `check("gain total", {1'b0, u, l[7:4]} + (x ? 13'h0040 : 13'h0000), gain_total_r)
            rd(8'hC1, 8'h00);
            `check("gain lower", {l[7:4], 4'h0}, rd_val)
            rd(8'hC2, 8'h00);
            `check("gain extra", {7'h00, x}, rd_val)
        end
    endtask
    task win(input [15:0] r, input acc, input exp);
        begin
            u_core.convert(r, acc, 3);
            `check("window irq", exp, window_irq_r)
            rd(8'hC3, 8'h00);
            `check("window flag", exp, rd_val[3])
            wr(8'hC3, 8'h00, 8'h00);
            repeat (2) @(posedge clk_sys);
            `check("flag cleared", 1'b0, window_irq_r)
        end
    endtask
    task lim(input [15:0] gt, input [15:0] lt);
        begin
            wr(8'hC4, gt[15:8], 8'h00);
            wr(8'hC5, gt[7:0], 8'h00);
            wr(8'hC6, lt[15:8], 8'h00);
            wr(8'hC7, lt[7:0], 8'h00);
        end
    endtask
    task t_reset;
        begin
            `check("total", 13'h0040, gain_total_r)
            `check("extra", 1'b1, extra_gain_bit_r)
            rd(8'hBA, 8'h00);
            `check("tracking reset", 8'hFF, rd_val)
            $display("reset test done");
        end
    endtask
    task t_gain;
        begin
            gcase(8'hFF, 8'hFF, 1'b1);
            gcase(8'h80, 8'h0F, 1'b0);
            gcase(8'h00, 8'h5A, 1'b1);
            $display("gain test done");
        end
    endtask
    task t_track;
        begin
            for (i = 0; i < 4; i++) begin
                wr(8'hBA, {4'hF, i[1:0], ~i[1:0]}, 8'h00);
                sar = (i == 3) ? 5'h02 : (i == 2) ? 5'h04 : 5'h10;
                repeat (2) @(posedge clk_sys);
                `check("mode", i[1:0], tracking_mode_sel_r)
                `check("reserved", (i == 0), tracking_mode_reserved_r)
                `check("sar clocks", sar, post_track_sar_clocks_r)
                `check("sys cycles", 5'h02, post_track_sys_cycles_r)
            end
            wr(8'hBA, 8'h55, 8'h01);
            rd(8'hBA, 8'h00);
            `check("other page write", 8'hFC, rd_val)
            rd(8'hBA, 8'h01);
            `check("other page read", 8'h00, rd_val)
            $display("tracking test done");
        end
    endtask
    task t_burst;
        begin
            for (i = 0; i < 4; i = i + 3) begin
                wr(8'hBA, {i[3:0], 4'h7}, 8'h00);
                wr(8'hC3, 8'h40, 8'h00);
                hi = 0;
                pk = 0;
                fork
                    u_core.convert(16'h0000, 1'b0, 2);
                    repeat ((i + 1) * 50 + 30) @(posedge clk_sys) begin
                        hi = hi + converter_power_r;
                        pk = pk + powerup_ready_r;
                    end
                join
                `check("powered cycles", (i + 1) * 50, hi)
                `check("ready pulses", 1, pk)
            end
            for (i = 0; i < 3; i++) begin
                wr(8'hC3, (i == 0) ? 8'hC0 : (i == 1) ? 8'h80 : 8'h00, 8'h00);
                repeat (10) @(posedge clk_sys);
                `check("power level", (i < 2), converter_power_r)
            end
            $display("burst test done");
        end
    endtask
    task t_window;
        begin
            lim(16'h0800, 16'h0400);
            win(16'h0600, 1'b1, 1'b0);
            win(16'h0900, 1'b0, 1'b0);
            win(16'h0900, 1'b1, 1'b1);
            win(16'h0800, 1'b1, 1'b0);
            win(16'h0300, 1'b1, 1'b1);
            lim(16'h0400, 16'h0800);
            win(16'h0600, 1'b1, 1'b1);
            win(16'h0900, 1'b1, 1'b0);
            $display("window test done");
        end
    endtask
    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            complete_run;
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        t_reset;
        t_gain;
        t_track;
        t_burst;
        t_window;
        complete_run;
    end
endmodule // adc_gain_track_window_ctrl_tb
